// ### rtl/ctu_edge_control.sv
// Charge time unit control: edges, status, current source, pulse and trigger
//
// Notes on behaviour
// - Any sleep forces current source off
// - Idle with stop-in-idle set disables source
// - Reset clears every control register to zero
// - Unit enable bit turns whole unit on
// - Time generation bit enables delay pulse generation
// - Edge pass bit clear blocks all edges
// - Sequence bit: edge two waits for one
// - Discharge bit grounds current source output
// - Trigger bit enables converter special event trigger
// - Edge two polarity: one rising, zero falling
// - Edge two source select, four sources
// - Edge one polarity: one rising, zero falling
// - Edge one source select, same encoding
// - Edge two status set by event, writable
// - Edge one status set by event, writable
// - Six-bit two's complement current trim field
// - Two-bit range: off, 1x, 10x, 100x
// - Delay select picks delay pin over comparator
// - Pulse emitted when selected delay input rises
// - Charge while edge one set, two clear
`timescale 1ns/1ps
`default_nettype none
module ctu_edge_control
    import ctu_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    input wire logic sleep_in,
    input wire logic idle_in,
    input wire logic edge_pin_one_in,
    input wire logic edge_pin_two_in,
    input wire logic compare_out_in,
    input wire logic timer_one_in,
    input wire logic delay_input_pin_in,
    input wire logic comparator_in,
    output logic [1:0] current_range_out,
    output logic [5:0] current_trim_out,
    output logic charge_out,
    output logic discharge_out,
    output logic trigger_out,
    output logic pulse_output_pin_out,
    output logic unit_interrupt_flag_out,
    output logic unit_interrupt_req_out,
    output logic unit_interrupt_priority_out,
    output logic [1:0] open_drain_out
);
    // Async inputs, bit order: 3 pin one, 2 pin two, 1 delay pin, 0 comparator
    typedef struct packed {
        logic [7:0] ctl_high;
        logic [7:0] ctl_low;
        logic [7:0] cur_ctl;
        logic [7:0] pd_od;
        logic irq_flag;
        logic irq_en;
        logic irq_pri;
        logic irq_req;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] sync3;
        logic [3:0] filt;
        logic [3:0] src_prev;
        logic [1:0] dly_prev;
        logic [7:0] rdata;
        logic [1:0] range_o;
        logic [5:0] trim_o;
        logic charge_o;
        logic ground_o;
        logic trig_o;
        logic pulse_o;
    } ctu_state_t;

    ctu_state_t st_reg;
    ctu_state_t st_next;

    logic [3:0] src_now;
    logic [3:0] src_rise;
    logic [3:0] src_fall;
    logic [1:0] sel_one;
    logic [1:0] sel_two;
    logic ev_one;
    logic ev_two;
    logic gate_ok;
    logic acc_one;
    logic acc_two;
    logic pwr_ok;
    logic dly_now;
    logic dly_rise;

    // Edge sources, indexed by select code; pins come from the filter stage
    assign src_now = {st_reg.filt[3], st_reg.filt[2], compare_out_in, timer_one_in};
    // Per-source edges so a change of select cannot fake an edge
    assign src_rise = src_now & ~st_reg.src_prev;
    assign src_fall = ~src_now & st_reg.src_prev;
    assign sel_one = st_reg.ctl_low[B_EDGE_ONE_SRC_HI:B_EDGE_ONE_SRC_LO];
    assign sel_two = st_reg.ctl_low[B_EDGE_TWO_SRC_HI:B_EDGE_TWO_SRC_LO];
    // Polarity picks rising or falling response
    assign ev_one = st_reg.ctl_low[B_EDGE_ONE_POL] ? src_rise[sel_one]
                                                   : src_fall[sel_one];
    assign ev_two = st_reg.ctl_low[B_EDGE_TWO_POL] ? src_rise[sel_two]
                                                   : src_fall[sel_two];
    // Unit on and edges unblocked
    assign gate_ok = st_reg.ctl_high[B_UNIT_ENABLE] & st_reg.ctl_high[B_EDGE_PASS_ENABLE];
    assign acc_one = gate_ok & ev_one;
    // Edge two waits for edge one status when sequencing
    assign acc_two = gate_ok & ev_two & (~st_reg.ctl_high[B_EDGE_SEQ_ENABLE]
                     | st_reg.ctl_low[B_EDGE_ONE_STATUS]);
    // Power gating of the current source
    assign pwr_ok = ~sleep_in & ~(idle_in & st_reg.ctl_high[B_STOP_IN_IDLE]);
    // Delay source: dedicated pin or comparator
    assign dly_now = st_reg.pd_od[B_PULSE_DELAY_SEL] ? st_reg.filt[1] : st_reg.filt[0];
    // Each delay input keeps its own history so a change of select cannot fake a rise
    assign dly_rise = dly_now & ~(st_reg.pd_od[B_PULSE_DELAY_SEL] ? st_reg.dly_prev[1]
                                                                  : st_reg.dly_prev[0]);

    // Next-state logic: bus writes first, hardware sets afterwards so sets win
    always_comb begin
        st_next = st_reg;
        // Three-stage sync; a change counts once stages two and three agree
        st_next.sync1 = {edge_pin_one_in, edge_pin_two_in, delay_input_pin_in, comparator_in};
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;
        for (int i = 0; i < 4; i++) begin
            if (st_reg.sync2[i] == st_reg.sync3[i]) begin
                st_next.filt[i] = st_reg.sync3[i];
            end
        end
        st_next.src_prev = src_now;
        st_next.dly_prev = st_reg.filt[1:0];

        // Register writes
        if (wr_in) begin
            if (addr_in == OFF_UNIT_CTL_HIGH) begin
                st_next.ctl_high = wdata_in & UNIT_CTL_HIGH_MASK;
            end else if (addr_in == OFF_EDGE_CTL_LOW) begin
                st_next.ctl_low = wdata_in;
            end else if (addr_in == OFF_CURRENT_SOURCE) begin
                st_next.cur_ctl = wdata_in;
            end else if (addr_in == OFF_PULSE_DELAY_OD) begin
                st_next.pd_od = wdata_in & PULSE_DELAY_OD_MASK;
            end else if (addr_in == OFF_IRQ_FLAGS_3) begin
                st_next.irq_flag = wdata_in[B_UNIT_IRQ];
            end else if (addr_in == OFF_IRQ_ENABLES_3) begin
                st_next.irq_en = wdata_in[B_UNIT_IRQ];
            end else if (addr_in == OFF_IRQ_PRIORITY_3) begin
                st_next.irq_pri = wdata_in[B_UNIT_IRQ];
            end
        end

        // Accepted edges set status; a same-cycle software clear loses
        if (acc_one) begin
            st_next.ctl_low[B_EDGE_ONE_STATUS] = 1'b1;
        end
        if (acc_two) begin
            st_next.ctl_low[B_EDGE_TWO_STATUS] = 1'b1;
            st_next.irq_flag = 1'b1;
        end

        // Read data stands only in the cycle after the strobe
        st_next.rdata = RST_BYTE;
        if (rd_in) begin
            if (addr_in == OFF_UNIT_CTL_HIGH) begin
                st_next.rdata = st_reg.ctl_high;
            end else if (addr_in == OFF_EDGE_CTL_LOW) begin
                st_next.rdata = st_reg.ctl_low;
            end else if (addr_in == OFF_CURRENT_SOURCE) begin
                st_next.rdata = st_reg.cur_ctl;
            end else if (addr_in == OFF_PULSE_DELAY_OD) begin
                st_next.rdata = st_reg.pd_od;
            end else if (addr_in == OFF_IRQ_FLAGS_3) begin
                st_next.rdata[B_UNIT_IRQ] = st_reg.irq_flag;
            end else if (addr_in == OFF_IRQ_ENABLES_3) begin
                st_next.rdata[B_UNIT_IRQ] = st_reg.irq_en;
            end else if (addr_in == OFF_IRQ_PRIORITY_3) begin
                st_next.rdata[B_UNIT_IRQ] = st_reg.irq_pri;
            end
        end

        // Current source: off unless enabled and power mode allows
        if (st_next.ctl_high[B_UNIT_ENABLE] & pwr_ok) begin
            st_next.range_o = st_next.cur_ctl[B_RANGE_HI:B_RANGE_LO];
        end else begin
            st_next.range_o = RANGE_OFF;
        end
        // Trim passes as a raw two's complement code to the analog side
        st_next.trim_o = st_next.cur_ctl[B_TRIM_HI:B_TRIM_LO];
        // Charging window between edge one and edge two
        st_next.charge_o = (st_next.range_o != RANGE_OFF)
                           & st_next.ctl_low[B_EDGE_ONE_STATUS]
                           & ~st_next.ctl_low[B_EDGE_TWO_STATUS];
        // Grounding is not gated by enable so a reset charge can be drained
        st_next.ground_o = st_next.ctl_high[B_DISCHARGE_CTL];
        // One-cycle trigger toward the converter on completion
        st_next.trig_o = acc_two & st_reg.ctl_high[B_TRIGGER_ENABLE];
        // One-cycle delay pulse while armed by edge one
        st_next.pulse_o = st_reg.ctl_high[B_UNIT_ENABLE]
                          & st_reg.ctl_high[B_TIME_GEN_ENABLE]
                          & st_reg.ctl_low[B_EDGE_ONE_STATUS] & dly_rise;
        // Request registered so the pin carries no gate after the flops
        st_next.irq_req = st_next.irq_flag & st_next.irq_en;
    end

    // State register; reset clears everything
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops
    assign rdata_out = st_reg.rdata;
    assign current_range_out = st_reg.range_o;
    assign current_trim_out = st_reg.trim_o;
    assign charge_out = st_reg.charge_o;
    assign discharge_out = st_reg.ground_o;
    assign trigger_out = st_reg.trig_o;
    assign pulse_output_pin_out = st_reg.pulse_o;
    assign unit_interrupt_flag_out = st_reg.irq_flag;
    assign unit_interrupt_req_out = st_reg.irq_req;
    assign unit_interrupt_priority_out = st_reg.irq_pri;
    assign open_drain_out = st_reg.pd_od[1:0];

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    property p_sleep_off;
        sleep_in |=> current_range_out == RANGE_OFF && !charge_out;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("source on in sleep");

    property p_idle_stop;
        idle_in && st_reg.ctl_high[B_STOP_IN_IDLE] && !wr_in |=> current_range_out == RANGE_OFF;
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("source on in idle");

    property p_reset_clear;
        @(posedge ref_clk_in) disable iff (1'b0)
        srst_in |=> st_reg.ctl_high == RST_BYTE && st_reg.ctl_low == RST_BYTE
                    && st_reg.cur_ctl == RST_BYTE && !charge_out;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

    property p_disabled;
        !st_reg.ctl_high[B_UNIT_ENABLE] && !wr_in |=> current_range_out == RANGE_OFF
                                                      && !pulse_output_pin_out;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled unit active");

    property p_blocked;
        !gate_ok && !wr_in |=> $stable(st_reg.ctl_low) && !trigger_out;
    endproperty
    a_blocked: assert property (p_blocked) else $error("blocked edge changed status");

    property p_sequence;
        st_reg.ctl_high[B_EDGE_SEQ_ENABLE] && !st_reg.ctl_low[B_EDGE_ONE_STATUS]
        && !st_reg.ctl_low[B_EDGE_TWO_STATUS] && !wr_in |=> !st_reg.ctl_low[B_EDGE_TWO_STATUS];
    endproperty
    a_sequence: assert property (p_sequence) else $error("edge two out of order");

    property p_ground;
        wr_in && addr_in == OFF_UNIT_CTL_HIGH |=> discharge_out == $past(wdata_in[B_DISCHARGE_CTL]);
    endproperty
    a_ground: assert property (p_ground) else $error("discharge not following bit");

    property p_trigger;
        trigger_out |-> $past(st_reg.ctl_high[B_TRIGGER_ENABLE])
                        && st_reg.ctl_low[B_EDGE_TWO_STATUS] && unit_interrupt_flag_out;
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger without cause");

    property p_charge;
        charge_out |-> st_reg.ctl_low[B_EDGE_ONE_STATUS] && !st_reg.ctl_low[B_EDGE_TWO_STATUS]
                       && current_range_out != RANGE_OFF;
    endproperty
    a_charge: assert property (p_charge) else $error("charging outside window");

    property p_pulse;
        pulse_output_pin_out |-> $past(st_reg.ctl_high[B_TIME_GEN_ENABLE]);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse while generation off");

    property p_irq;
        acc_two |=> unit_interrupt_flag_out && st_reg.ctl_low[B_EDGE_TWO_STATUS];
    endproperty
    a_irq: assert property (p_irq) else $error("completion lost");

    // Range reaches the source only while the unit is on and awake
    property p_range_follow;
        st_reg.ctl_high[B_UNIT_ENABLE] && !sleep_in && !idle_in && !wr_in
        |=> current_range_out == st_reg.cur_ctl[B_RANGE_HI:B_RANGE_LO];
    endproperty
    a_range_follow: assert property (p_range_follow) else $error("range not applied");

    // Idle alone leaves the source running when stop-in-idle is clear
    property p_idle_run;
        idle_in && !st_reg.ctl_high[B_STOP_IN_IDLE] && st_reg.ctl_high[B_UNIT_ENABLE]
        && !sleep_in && !wr_in |=> current_range_out == st_reg.cur_ctl[B_RANGE_HI:B_RANGE_LO];
    endproperty
    a_idle_run: assert property (p_idle_run) else $error("source stopped in idle");

    // Trim code and discharge level mirror their register bits every cycle
    property p_trim;
        current_trim_out == st_reg.cur_ctl[B_TRIM_HI:B_TRIM_LO];
    endproperty
    a_trim: assert property (p_trim) else $error("trim code lost");

    property p_ground_level;
        discharge_out == st_reg.ctl_high[B_DISCHARGE_CTL];
    endproperty
    a_ground_level: assert property (p_ground_level) else $error("discharge drifted");

    // Status bits move up only on an accepted edge or a bus write
    property p_one_cause;
        !st_reg.ctl_low[B_EDGE_ONE_STATUS] && !acc_one && !wr_in
        |=> !st_reg.ctl_low[B_EDGE_ONE_STATUS];
    endproperty
    a_one_cause: assert property (p_one_cause) else $error("stray edge one status");

    property p_two_cause;
        !st_reg.ctl_low[B_EDGE_TWO_STATUS] && !acc_two && !wr_in
        |=> !st_reg.ctl_low[B_EDGE_TWO_STATUS];
    endproperty
    a_two_cause: assert property (p_two_cause) else $error("stray edge two status");

    property p_one_set;
        acc_one |=> st_reg.ctl_low[B_EDGE_ONE_STATUS];
    endproperty
    a_one_set: assert property (p_one_set) else $error("edge one lost");

    // Without sequencing an edge two event is taken at once
    property p_seq_free;
        gate_ok && ev_two && !st_reg.ctl_high[B_EDGE_SEQ_ENABLE]
        |=> st_reg.ctl_low[B_EDGE_TWO_STATUS];
    endproperty
    a_seq_free: assert property (p_seq_free) else $error("edge two refused");

    property p_trig_off;
        !st_reg.ctl_high[B_TRIGGER_ENABLE] |=> !trigger_out;
    endproperty
    a_trig_off: assert property (p_trig_off) else $error("trigger while disabled");

    // Charging follows the status window whenever the source is on
    property p_charge_on;
        st_reg.ctl_low[B_EDGE_ONE_STATUS] && !st_reg.ctl_low[B_EDGE_TWO_STATUS]
        && current_range_out != RANGE_OFF |-> charge_out;
    endproperty
    a_charge_on: assert property (p_charge_on) else $error("window without charge");

    property p_pulse_armed;
        pulse_output_pin_out |-> $past(st_reg.ctl_high[B_UNIT_ENABLE])
                                 && $past(st_reg.ctl_low[B_EDGE_ONE_STATUS]);
    endproperty
    a_pulse_armed: assert property (p_pulse_armed) else $error("pulse while not armed");

    // Request pin is the flag qualified by its enable
    property p_irq_req;
        unit_interrupt_req_out == (unit_interrupt_flag_out && st_reg.irq_en);
    endproperty
    a_irq_req: assert property (p_irq_req) else $error("request not flag and enable");

    // Main scenarios: charge window, trigger, pulse, refused edge two, sleep
    c_charge: cover property (charge_out ##[1:50] !charge_out);
    c_seq_refused: cover property (st_reg.ctl_high[B_EDGE_SEQ_ENABLE] && gate_ok && ev_two
                                   && !st_reg.ctl_low[B_EDGE_ONE_STATUS]);
    c_sleep: cover property (sleep_in && st_reg.ctl_high[B_UNIT_ENABLE]);
    c_trigger: cover property (trigger_out);
    c_pulse: cover property (pulse_output_pin_out);
endmodule
`default_nettype wire

// ### rtl/ctu_pkg.sv
// Package: register map, field positions and reset values of the charge time unit
package ctu_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [11:0] OFF_PULSE_DELAY_OD = 12'hF40;
    localparam logic [11:0] OFF_CURRENT_SOURCE = 12'hFB1;
    localparam logic [11:0] OFF_EDGE_CTL_LOW = 12'hFB2;
    localparam logic [11:0] OFF_UNIT_CTL_HIGH = 12'hFB3;
    localparam logic [11:0] OFF_IRQ_FLAGS_3 = 12'hF10;
    localparam logic [11:0] OFF_IRQ_ENABLES_3 = 12'hF11;
    localparam logic [11:0] OFF_IRQ_PRIORITY_3 = 12'hF12;
    // Unit control high fields
    localparam int B_UNIT_ENABLE = 7;
    localparam int B_STOP_IN_IDLE = 5;
    localparam int B_TIME_GEN_ENABLE = 4;
    localparam int B_EDGE_PASS_ENABLE = 3;
    localparam int B_EDGE_SEQ_ENABLE = 2;
    localparam int B_DISCHARGE_CTL = 1;
    localparam int B_TRIGGER_ENABLE = 0;
    localparam logic [7:0] UNIT_CTL_HIGH_MASK = 8'hBF;
    // Edge control low fields
    localparam int B_EDGE_TWO_POL = 7;
    localparam int B_EDGE_TWO_SRC_HI = 6;
    localparam int B_EDGE_TWO_SRC_LO = 5;
    localparam int B_EDGE_ONE_POL = 4;
    localparam int B_EDGE_ONE_SRC_HI = 3;
    localparam int B_EDGE_ONE_SRC_LO = 2;
    localparam int B_EDGE_TWO_STATUS = 1;
    localparam int B_EDGE_ONE_STATUS = 0;
    // Current source control fields
    localparam int B_TRIM_HI = 7;
    localparam int B_TRIM_LO = 2;
    localparam int B_RANGE_HI = 1;
    localparam int B_RANGE_LO = 0;
    localparam logic [1:0] RANGE_OFF = 2'h0;
    // Source select codes: index into the source vector
    localparam logic [1:0] SRC_TIMER_ONE = 2'h0;
    localparam logic [1:0] SRC_COMPARE = 2'h1;
    localparam logic [1:0] SRC_PIN_TWO = 2'h2;
    localparam logic [1:0] SRC_PIN_ONE = 2'h3;
    // Pulse delay / open-drain register fields
    localparam int B_PULSE_DELAY_SEL = 7;
    localparam logic [7:0] PULSE_DELAY_OD_MASK = 8'h83;
    // Interrupt bit position in the flag, enable and priority registers
    localparam int B_UNIT_IRQ = 2;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// ### tb/charge_time_edge_control_tb.sv
// Self-checking bench for the charge time unit control block
`timescale 1ns/1ps
`default_nettype none
module charge_time_edge_control_tb;
    import ctu_pkg::*;
    localparam int LIMIT = 6000;
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [ADDR_W-1:0] addr_in = 12'h000;
    logic [DATA_W-1:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic sleep_in = 1'b0;
    logic idle_in = 1'b0;
    logic [DATA_W-1:0] rdata;
    wire logic e1, e2, cmpo, tmr, dly, cmpr;
    logic [1:0] range, odr, sv, ov;
    logic [5:0] trim;
    logic chg, dis, trig, pls, irqf, irqr, irqp;
    logic [7:0] cfg;
    int n_fail = 0;
    int comparisons = 0;
    int n_pulse = 0;
    int n_trig = 0;
    int cycles = 0;
    logic [11:0] offs [8] = '{OFF_PULSE_DELAY_OD, OFF_CURRENT_SOURCE, OFF_EDGE_CTL_LOW,
        OFF_UNIT_CTL_HIGH, OFF_IRQ_FLAGS_3, OFF_IRQ_ENABLES_3, OFF_IRQ_PRIORITY_3, 12'h000};
    logic [5:0] trims [4] = '{6'h00, 6'h1F, 6'h21, 6'h3F};

    ctu_edge_control ctu_edge_control_inst (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
        .sleep_in(sleep_in), .idle_in(idle_in), .edge_pin_one_in(e1),
        .edge_pin_two_in(e2), .compare_out_in(cmpo), .timer_one_in(tmr),
        .delay_input_pin_in(dly), .comparator_in(cmpr), .current_range_out(range),
        .current_trim_out(trim), .charge_out(chg), .discharge_out(dis),
        .trigger_out(trig), .pulse_output_pin_out(pls), .unit_interrupt_flag_out(irqf),
        .unit_interrupt_req_out(irqr), .unit_interrupt_priority_out(irqp),
        .open_drain_out(odr)
    );
    ctu_edge_sources ctu_edge_sources_inst (
        .ref_clk_in(ref_clk_in), .timer_one_out(tmr), .compare_out(cmpo),
        .edge_pin_two_out(e2), .edge_pin_one_out(e1), .delay_pin_out(dly),
        .comparator_out(cmpr)
    );

    always #20 ref_clk_in = ~ref_clk_in;

    // One-cycle pulses are counted at every rising edge; the cycle ceiling cuts a hang short
    always @(posedge ref_clk_in) begin
        cycles++;
        if (pls === 1'b1) n_pulse++;
        if (trig === 1'b1) n_trig++;
        if (cycles == LIMIT) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    // Write strobe stands one cycle; outputs are looked at once the edge has landed
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic src(input int i, input logic v);
        ctu_edge_sources_inst.drive(i, v);
    endtask

    task automatic pwr(input logic s, input logic i, input logic [1:0] exp);
        @(posedge ref_clk_in);
        sleep_in <= s;
        idle_in <= i;
        tick(2);
        chk({6'h00, range}, {6'h00, exp});
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    initial begin
        repeat (2) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        // Everything comes up cleared, unmapped place included
        for (int i = 0; i < 8; i++) rd(offs[i], RST_BYTE);
        chk({trim, range}, 8'h00);
        chk({dis, chg, trig, pls, irqf, irqr, irqp, 1'b0}, 8'h00);
        wr(OFF_UNIT_CTL_HIGH, 8'hFF);
        rd(OFF_UNIT_CTL_HIGH, 8'hBF);
        wr(OFF_UNIT_CTL_HIGH, 8'h80);
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CURRENT_SOURCE, {trims[i], i[1:0]});
            rd(OFF_CURRENT_SOURCE, {trims[i], i[1:0]});
            chk({trim, range}, {trims[i], i[1:0]});
        end
        wr(OFF_PULSE_DELAY_OD, 8'hFF);
        rd(OFF_PULSE_DELAY_OD, 8'h83);
        chk({6'h00, odr}, 8'h03);
        wr(OFF_PULSE_DELAY_OD, 8'h00);
        wr(12'h000, 8'hFF);
        rd(12'h000, 8'h00);
        done("registers");
        // Drain the measured circuit by setting then clearing discharge
        wr(OFF_UNIT_CTL_HIGH, 8'h82);
        chk({7'h00, dis}, 8'h01);
        wr(OFF_UNIT_CTL_HIGH, 8'h80);
        chk({7'h00, dis}, 8'h00);
        wr(OFF_CURRENT_SOURCE, 8'h02);
        pwr(1'b1, 1'b0, 2'h0);
        pwr(1'b0, 1'b0, 2'h2);
        pwr(1'b0, 1'b1, 2'h2);
        wr(OFF_UNIT_CTL_HIGH, 8'hA0);
        pwr(1'b0, 1'b1, 2'h0);
        pwr(1'b0, 1'b0, 2'h2);
        done("power");
        // Edge one timer rising, edge two compare rising
        wr(OFF_EDGE_CTL_LOW, 8'hB0);
        wr(OFF_UNIT_CTL_HIGH, 8'h81);
        src(0, 1'b1);
        tick(3);
        rd(OFF_EDGE_CTL_LOW, 8'hB0);
        src(0, 1'b0);
        wr(OFF_UNIT_CTL_HIGH, 8'h8D);
        src(1, 1'b1);
        tick(3);
        rd(OFF_EDGE_CTL_LOW, 8'hB0);
        src(1, 1'b0);
        src(0, 1'b1);
        tick(3);
        rd(OFF_EDGE_CTL_LOW, 8'hB1);
        chk({7'h00, chg}, 8'h01);
        src(1, 1'b1);
        tick(3);
        rd(OFF_EDGE_CTL_LOW, 8'hB3);
        chk({7'h00, chg}, 8'h00);
        chk(n_trig[7:0], 8'h01);
        rd(OFF_IRQ_FLAGS_3, 8'h04);
        wr(OFF_IRQ_ENABLES_3, 8'h04);
        rd(OFF_IRQ_ENABLES_3, 8'h04);
        wr(OFF_IRQ_PRIORITY_3, 8'hFF);
        rd(OFF_IRQ_PRIORITY_3, 8'h04);
        chk({6'h00, irqr, irqp}, 8'h03);
        wr(OFF_IRQ_FLAGS_3, 8'h00);
        chk({6'h00, irqf, irqr}, 8'h00);
        wr(OFF_EDGE_CTL_LOW, 8'hB1);
        chk({7'h00, chg}, 8'h01);
        wr(OFF_EDGE_CTL_LOW, 8'hB0);
        chk({7'h00, chg}, 8'h00);
        src(0, 1'b0);
        src(1, 1'b0);
        done("edges");
        // Every source for both edges, falling response; the rise must not count
        wr(OFF_UNIT_CTL_HIGH, 8'h88);
        for (int e = 1; e < 3; e++) begin
            for (int s = 0; s < 4; s++) begin
                sv = s[1:0];
                ov = sv + 2'h1;
                cfg = (e == 1) ? {1'b1, ov, 1'b0, sv, 2'h0} : {1'b0, sv, 1'b1, ov, 2'h0};
                wr(OFF_EDGE_CTL_LOW, cfg);
                src(s, 1'b1);
                tick(8);
                rd(OFF_EDGE_CTL_LOW, cfg);
                src(s, 1'b0);
                tick(8);
                rd(OFF_EDGE_CTL_LOW, cfg | 8'(e));
            end
        end
        chk(n_trig[7:0], 8'h01);
        done("sources");
        // Armed delay pulse: pin path, comparator path, then generation off
        wr(OFF_UNIT_CTL_HIGH, 8'h90);
        wr(OFF_EDGE_CTL_LOW, 8'h01);
        wr(OFF_PULSE_DELAY_OD, 8'h80);
        src(4, 1'b1);
        tick(8);
        chk(n_pulse[7:0], 8'h01);
        src(4, 1'b0);
        src(5, 1'b1);
        tick(8);
        chk(n_pulse[7:0], 8'h01);
        src(5, 1'b0);
        wr(OFF_PULSE_DELAY_OD, 8'h00);
        src(5, 1'b1);
        tick(8);
        chk(n_pulse[7:0], 8'h02);
        src(5, 1'b0);
        wr(OFF_UNIT_CTL_HIGH, 8'h80);
        src(5, 1'b1);
        tick(8);
        chk(n_pulse[7:0], 8'h02);
        done("pulse");
        // Reset in mid-run clears the unit again
        @(posedge ref_clk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        rd(OFF_EDGE_CTL_LOW, 8'h00);
        rd(OFF_UNIT_CTL_HIGH, 8'h00);
        done("reset");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ### tb/ctu_edge_sources.sv
// Far-side model: edge sources and delay inputs seen by the charge time unit
`timescale 1ns/1ps
`default_nettype none
module ctu_edge_sources (
    input wire logic ref_clk_in,
    output logic timer_one_out,
    output logic compare_out,
    output logic edge_pin_two_out,
    output logic edge_pin_one_out,
    output logic delay_pin_out,
    output logic comparator_out
);
    // Index follows the source select code, then delay pin and comparator
    logic [5:0] level_reg = 6'h00;
    // Levels move just after an edge, like the on-chip timer and compare do
    task automatic drive(input int idx, input logic val);
        @(posedge ref_clk_in);
        level_reg[idx] <= val;
    endtask
    // Every source holds its level until told to move
    assign timer_one_out = level_reg[0];
    assign compare_out = level_reg[1];
    assign edge_pin_two_out = level_reg[2];
    assign edge_pin_one_out = level_reg[3];
    assign delay_pin_out = level_reg[4];
    assign comparator_out = level_reg[5];
endmodule
`default_nettype wire
